// ### hw/vci_inserter.sv
// Caption and copy-generation inserter for the composite line generator.
// Assumes LINE_START pulses once per line with LINE_NUM valid for that line,
// NTSC_MODE steady, and a classic Wishbone master for the registers.
//
// Function
// - Captions on line 21 and line 284
// - Seven-cycle run-in sine at bit rate
// - Two blank bits, then start bit one
// - Two bytes: seven bits plus odd parity
// - Extended caption registers used on line 284
// - Internal timing; pixels ignored on caption lines
// - Single byte buffer, no frame delay
// - Copy word on lines 20 and 283
// - Per-field copy enable bits
// - Copy word only in NTSC mode
// - Twenty bits after one-bit reference pulse
// - Register bits map onto payload bits
// - Auto CRC replaces payload bits 14-19
// - CRC x^6+x+1 preset to ones
// - Without auto CRC send registers directly
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module vci_inserter
    import vci_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic LINE_START,
    input wire logic [9:0] LINE_NUM,
    input wire logic NTSC_MODE,
    input wire logic [7:0] PIX_IN,
    output logic [7:0] PIX_OUT,
    output logic VBI_ACTIVE
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [7:0] cc_byte(input logic [7:0] d);
        cc_byte = {~^d[6:0], d[6:0]};
    endfunction

    function automatic logic [5:0] crc6(input logic [13:0] d);
        logic [5:0] c;
        logic fb;
        c = CRC_PRESET;
        for (int i = 0; i < 14; i++) begin
            fb = d[i] ^ c[5];
            c = {c[4:0], fb} ^ {4'h0, fb, 1'b0};
        end
        crc6 = {c[0], c[1], c[2], c[3], c[4], c[5]};
    endfunction

    function automatic logic [7:0] sine_lvl(input logic [2:0] ph);
        case (ph)
            3'd0: sine_lvl = 8'h47;
            3'd1: sine_lvl = 8'h6b;
            3'd2: sine_lvl = 8'h7e;
            3'd3: sine_lvl = 8'h6b;
            3'd4: sine_lvl = 8'h47;
            3'd5: sine_lvl = 8'h23;
            3'd6: sine_lvl = 8'h10;
            default: sine_lvl = 8'h23;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] ctrl_reg, ctrl_next;
    logic [7:0] copy0_reg, copy0_next, copy1_reg, copy1_next, copy2_reg, copy2_next;
    logic [7:0] cc0_reg, cc0_next, cc1_reg, cc1_next;
    logic [7:0] ccx0_reg, ccx0_next, ccx1_reg, ccx1_next;
    logic ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;
    logic wr_en;
    logic [7:0] status;

    vci_state_t state_reg, state_next;
    logic is_cc_reg, is_cc_next;
    logic cc_line_reg, cc_line_next;
    logic crc_reg, crc_next;
    logic [20:0] shift_reg, shift_next;
    logic [11:0] cyc_reg, cyc_next;
    logic [4:0] bit_reg, bit_next;
    logic [7:0] pix_reg, pix_next;
    logic act_reg, act_next;

    assign wr_en = WB_CYC_I && WB_STB_I && WB_WE_I && !ack_reg && WB_SEL_I[0];
    assign status = {5'h0, is_cc_reg, cc_line_reg, state_reg != S_IDLE};

    always_comb begin
        ctrl_next = ctrl_reg;
        copy0_next = copy0_reg;
        copy1_next = copy1_reg;
        copy2_next = copy2_reg;
        cc0_next = cc0_reg;
        cc1_next = cc1_reg;
        ccx0_next = ccx0_reg;
        ccx1_next = ccx1_reg;
        ack_next = WB_CYC_I && WB_STB_I && !ack_reg;
        rdat_next = 32'h0;
        if (wr_en) begin
            case (WB_ADR_I)
                ADR_CTRL: ctrl_next = {3'h0, WB_DAT_I[4:0]};
                ADR_COPY0: copy0_next = {4'h0, WB_DAT_I[3:0]};
                ADR_COPY1: copy1_next = WB_DAT_I[7:0];
                ADR_COPY2: copy2_next = WB_DAT_I[7:0];
                ADR_CC0: cc0_next = WB_DAT_I[7:0];
                ADR_CC1: cc1_next = WB_DAT_I[7:0];
                ADR_CCX0: ccx0_next = WB_DAT_I[7:0];
                ADR_CCX1: ccx1_next = WB_DAT_I[7:0];
                default: ;
            endcase
        end
        if (WB_CYC_I && WB_STB_I && !WB_WE_I && !ack_reg) begin
            case (WB_ADR_I)
                ADR_CTRL: rdat_next = {24'h0, ctrl_reg};
                ADR_COPY0: rdat_next = {24'h0, copy0_reg};
                ADR_COPY1: rdat_next = {24'h0, copy1_reg};
                ADR_COPY2: rdat_next = {24'h0, copy2_reg};
                ADR_CC0: rdat_next = {24'h0, cc0_reg};
                ADR_CC1: rdat_next = {24'h0, cc1_reg};
                ADR_CCX0: rdat_next = {24'h0, ccx0_reg};
                ADR_CCX1: rdat_next = {24'h0, ccx1_reg};
                ADR_STATUS: rdat_next = {24'h0, status};
                default: rdat_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_reg <= RST_CTRL;
            copy0_reg <= RST_DATA;
            copy1_reg <= RST_DATA;
            copy2_reg <= RST_DATA;
            cc0_reg <= RST_DATA;
            cc1_reg <= RST_DATA;
            ccx0_reg <= RST_DATA;
            ccx1_reg <= RST_DATA;
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0;
        end else begin
            ctrl_reg <= ctrl_next;
            copy0_reg <= copy0_next;
            copy1_reg <= copy1_next;
            copy2_reg <= copy2_next;
            cc0_reg <= cc0_next;
            cc1_reg <= cc1_next;
            ccx0_reg <= ccx0_next;
            ccx1_reg <= ccx1_next;
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
        end
    end

    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = rdat_reg;

    // ------------------------------------------------------------
    // Line sequencer
    // ------------------------------------------------------------
    // Frames are loaded from the registers at the start of the line itself,
    // so a write made any time before that line goes out at once.
    logic go_cc_odd, go_cc_even, go_cg_odd, go_cg_even;
    logic [13:0] cg_low;
    logic [5:0] cg_high;
    logic [11:0] bit_len;
    logic [4:0] frame_bits;

    assign go_cc_odd = LINE_START && LINE_NUM == LINE_CC_ODD && ctrl_reg[CTRL_ODD_CC];
    assign go_cc_even = LINE_START && LINE_NUM == LINE_CC_EVEN && ctrl_reg[CTRL_EVEN_CC];
    assign go_cg_odd = LINE_START && LINE_NUM == LINE_CG_ODD && NTSC_MODE
        && ctrl_reg[CTRL_ODD_COPY];
    assign go_cg_even = LINE_START && LINE_NUM == LINE_CG_EVEN && NTSC_MODE
        && ctrl_reg[CTRL_EVEN_COPY];
    assign cg_low = {copy1_reg[5:0], copy2_reg};
    assign cg_high = ctrl_reg[CTRL_CRC_AUTO] ? crc6(cg_low)
        : {copy0_reg[3:0], copy1_reg[7:6]};
    assign bit_len = is_cc_reg ? CC_BIT_CYC : CG_BIT_CYC;
    assign frame_bits = is_cc_reg ? CC_FRAME_BITS : CG_FRAME_BITS;

    always_comb begin
        state_next = state_reg;
        is_cc_next = is_cc_reg;
        cc_line_next = cc_line_reg;
        crc_next = crc_reg;
        shift_next = shift_reg;
        cyc_next = cyc_reg + 12'd1;
        bit_next = bit_reg;
        case (state_reg)
            S_IDLE: cyc_next = 12'd0;
            S_DELAY: begin
                if (cyc_reg == (is_cc_reg ? CC_START_CYC : CG_START_CYC) - 12'd1) begin
                    cyc_next = 12'd0;
                    state_next = is_cc_reg ? S_RUNIN : S_BITS;
                end
            end
            S_RUNIN: begin
                if (cyc_reg == RUNIN_CYC - 12'd1) begin
                    cyc_next = 12'd0;
                    state_next = S_BITS;
                end
            end
            S_BITS: begin
                if (cyc_reg == bit_len - 12'd1) begin
                    cyc_next = 12'd0;
                    shift_next = {1'b0, shift_reg[20:1]};
                    bit_next = bit_reg + 5'd1;
                    if (bit_reg == frame_bits - 5'd1) begin
                        state_next = S_IDLE;
                    end
                end
            end
            default: state_next = S_IDLE;
        endcase
        if (LINE_START) begin
            // A new line always aborts whatever was still running
            state_next = S_IDLE;
            cyc_next = 12'd0;
            bit_next = 5'd0;
            cc_line_next = LINE_NUM == LINE_CC_ODD || LINE_NUM == LINE_CC_EVEN;
            crc_next = ctrl_reg[CTRL_CRC_AUTO];
            if (go_cc_odd || go_cc_even) begin
                state_next = S_DELAY;
                is_cc_next = 1'b1;
                // Two blank bits, start bit, then byte 0 and byte 1
                shift_next = go_cc_odd
                    ? {2'b00, cc_byte(cc1_reg), cc_byte(cc0_reg), 3'b100}
                    : {2'b00, cc_byte(ccx1_reg), cc_byte(ccx0_reg), 3'b100};
            end else if (go_cg_odd || go_cg_even) begin
                state_next = S_DELAY;
                is_cc_next = 1'b0;
                shift_next = {cg_high, cg_low, 1'b1};
            end
        end
    end

    // The pixel presented with LINE_START already belongs to the new line,
    // so the caption-line blanking follows the next value, not the registered one.
    always_comb begin
        pix_next = PIX_IN;
        act_next = cc_line_next;
        case (state_reg)
            S_RUNIN: pix_next = sine_lvl(3'((32'(cyc_reg) * 8 / 32'(CC_BIT_CYC)) % 8));
            S_BITS: pix_next = shift_reg[0] ? (is_cc_reg ? LVL_CC_HIGH : LVL_CG_HIGH)
                : LVL_BLANK;
            default: pix_next = cc_line_next ? LVL_BLANK : PIX_IN;
        endcase
        if (state_reg == S_RUNIN || state_reg == S_BITS) begin
            act_next = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_reg <= S_IDLE;
            is_cc_reg <= 1'b0;
            cc_line_reg <= 1'b0;
            crc_reg <= 1'b0;
            shift_reg <= 21'h0;
            cyc_reg <= 12'h0;
            bit_reg <= 5'h0;
            pix_reg <= LVL_BLANK;
            act_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            is_cc_reg <= is_cc_next;
            cc_line_reg <= cc_line_next;
            crc_reg <= crc_next;
            shift_reg <= shift_next;
            cyc_reg <= cyc_next;
            bit_reg <= bit_next;
            pix_reg <= pix_next;
            act_reg <= act_next;
        end
    end

    assign PIX_OUT = pix_reg;
    assign VBI_ACTIVE = act_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_ack_single_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");
    a_ack_after_req: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not answered next cycle");
    a_cc_runin_len: assert property (state_reg == S_RUNIN && cyc_reg == RUNIN_CYC - 12'd1
        && !LINE_START |=> state_reg == S_BITS)
        else $error("run-in length wrong");
    a_cc_blank_gap: assert property (state_reg == S_BITS && is_cc_reg && bit_reg < 5'd2
        |=> PIX_OUT == LVL_BLANK)
        else $error("blank gap not at blanking level");
    a_cc_start_bit: assert property (state_reg == S_BITS && is_cc_reg && bit_reg == 5'd2
        |=> PIX_OUT == LVL_CC_HIGH)
        else $error("start bit not high");
    a_cc_line_ignore: assert property (cc_line_reg && !LINE_START |=> VBI_ACTIVE)
        else $error("pixel input passed on caption line");
    a_copy_pal_block: assert property (LINE_START && !NTSC_MODE
        && (LINE_NUM == LINE_CG_ODD || LINE_NUM == LINE_CG_EVEN) |=> state_reg == S_IDLE)
        else $error("copy word started in PAL mode");
    a_copy_field_en: assert property (LINE_START && LINE_NUM == LINE_CG_EVEN
        && !ctrl_reg[CTRL_EVEN_COPY] |=> state_reg == S_IDLE)
        else $error("copy word sent in disabled field");
    a_copy_crc_bits: assert property (state_reg == S_DELAY && !is_cc_reg && crc_reg
        |-> shift_reg[20:15] == crc6(shift_reg[14:1]))
        else $error("auto CRC bits wrong");
    a_copy_ref_pulse: assert property (state_reg == S_BITS && !is_cc_reg && bit_reg == 5'd0
        |=> PIX_OUT == LVL_CG_HIGH)
        else $error("reference pulse missing");

    c_cc_line: cover property (state_reg == S_RUNIN ##1 state_reg == S_BITS);
    c_copy_done: cover property (state_reg == S_BITS && !is_cc_reg ##1 state_reg == S_IDLE);
    c_bus_write: cover property (wr_en && WB_ADR_I == ADR_CC0);

endmodule // vci_inserter

// ### shared/vci_pkg.sv
// Constants for the vertical-blanking caption and copy-generation inserter.
// Assumes a 250 MHz pixel-side clock and 8-bit registers on a 32-bit Wishbone bus.
package vci_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int CC_BIT_PS = 1986000;
    localparam int CC_START_PS = 10500000;
    localparam int CG_BIT_PS = 2235000;
    localparam int CG_START_PS = 11200000;
    localparam logic [11:0] CC_BIT_CYC = 12'(CC_BIT_PS / CLK_PERIOD_PS);
    localparam logic [11:0] CC_START_CYC = 12'(CC_START_PS / CLK_PERIOD_PS);
    localparam logic [11:0] CG_BIT_CYC = 12'(CG_BIT_PS / CLK_PERIOD_PS);
    localparam logic [11:0] CG_START_CYC = 12'(CG_START_PS / CLK_PERIOD_PS);
    localparam logic [2:0] RUNIN_CYCLES = 3'd7;
    localparam logic [11:0] RUNIN_CYC = 12'(7 * (CC_BIT_PS / CLK_PERIOD_PS));

    // ------------------------------------------------------------
    // Lines and frame lengths
    // ------------------------------------------------------------
    localparam logic [9:0] LINE_CC_ODD = 10'd21;
    localparam logic [9:0] LINE_CC_EVEN = 10'd284;
    localparam logic [9:0] LINE_CG_ODD = 10'd20;
    localparam logic [9:0] LINE_CG_EVEN = 10'd283;
    localparam logic [4:0] CC_FRAME_BITS = 5'd19;
    localparam logic [4:0] CG_FRAME_BITS = 5'd21;
    localparam logic [5:0] CRC_PRESET = 6'h3f;

    // ------------------------------------------------------------
    // Output levels
    // ------------------------------------------------------------
    localparam logic [7:0] LVL_BLANK = 8'h10;
    localparam logic [7:0] LVL_CC_HIGH = 8'h7e;
    localparam logic [7:0] LVL_CG_HIGH = 8'h9a;

    // ------------------------------------------------------------
    // Register map (byte addresses) and control fields
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_COPY0 = 8'h04;
    localparam logic [7:0] ADR_COPY1 = 8'h08;
    localparam logic [7:0] ADR_COPY2 = 8'h0c;
    localparam logic [7:0] ADR_CC0 = 8'h10;
    localparam logic [7:0] ADR_CC1 = 8'h14;
    localparam logic [7:0] ADR_CCX0 = 8'h18;
    localparam logic [7:0] ADR_CCX1 = 8'h1c;
    localparam logic [7:0] ADR_STATUS = 8'h20;
    localparam int CTRL_CRC_AUTO = 0;
    localparam int CTRL_ODD_COPY = 1;
    localparam int CTRL_EVEN_COPY = 2;
    localparam int CTRL_ODD_CC = 3;
    localparam int CTRL_EVEN_CC = 4;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_DATA = 8'h00;

    typedef enum logic [1:0] {S_IDLE, S_DELAY, S_RUNIN, S_BITS} vci_state_t;

endpackage : vci_pkg

// ### dv/vci_rx_model.sv
// Receiver model: slices the caption and copy-generation lines off PIX_OUT.
// Assumes LINE_START is the pulse the inserter sees; bits are read at their centres.
`timescale 1ns/1ps
module vci_rx_model
    import vci_pkg::*;
(
    input wire logic CLK,
    input wire logic LINE_START,
    input wire logic [7:0] PIX_OUT,
    output logic [18:0] cc_bits,
    output logic [20:0] cg_bits,
    output logic [3:0] runin_peaks
);
    // ------------------------------------------------------------
    // Bit slicer
    // ------------------------------------------------------------
    localparam int CCB = int'(CC_BIT_CYC);
    localparam int CGB = int'(CG_BIT_CYC);
    localparam int RUN0 = int'(CC_START_CYC);
    localparam int RUN1 = RUN0 + int'(RUNIN_CYC);
    localparam int CC_MID = RUN1 + CCB / 2;
    localparam int CG_MID = int'(CG_START_CYC) + CGB / 2;
    // Halfway between blank and caption high, so both pulse heights slice alike
    localparam logic [7:0] SLICE = 8'h47;
    int cnt = 0;
    logic hi;
    logic hi_prev = 1'b0;
    assign hi = PIX_OUT > SLICE;
    always @(posedge CLK) begin
        hi_prev <= hi;
        if (LINE_START) begin
            cnt <= 0;
            cc_bits <= '0;
            cg_bits <= '0;
            runin_peaks <= '0;
        end else begin
            cnt <= cnt + 1;
            if (cnt >= CC_MID && (cnt - CC_MID) % CCB == 0 && (cnt - CC_MID) / CCB < 19) begin
                cc_bits[(cnt - CC_MID) / CCB] <= hi;
            end
            if (cnt >= CG_MID && (cnt - CG_MID) % CGB == 0 && (cnt - CG_MID) / CGB < 21) begin
                cg_bits[(cnt - CG_MID) / CGB] <= hi;
            end
            // Margin on both sides tolerates any start phase of the sine
            if (cnt > RUN0 - 8 && cnt < RUN1 + 8 && hi && !hi_prev) begin
                runin_peaks <= runin_peaks + 4'h1;
            end
        end
    end
endmodule // vci_rx_model

// ### dv/tb_vbi_caption_copy_generation_info_inserter.sv
// Self-checking bench for the caption and copy-generation inserter.
// Assumes the receiver model slices PIX_OUT and registers are on Wishbone.
`timescale 1ns/1ps
module tb_vbi_caption_copy_generation_info_inserter;
    import vci_pkg::*;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ls = 1'b0, ntsc = 1'b1;
    logic [7:0] adr = 8'h00, pix = 8'h55, pix_out;
    logic [9:0] num = 10'h000;
    logic [31:0] dat = 32'h0, rdat, rd;
    logic ack, vbi;
    logic [18:0] cc_bits;
    logic [20:0] cg_bits;
    logic [3:0] peaks;
    int errors = 0, samples_checked = 0, leaks = 0;

    always #2 clk = ~clk;
    always @(posedge clk) if (pix_out === 8'hff) leaks <= leaks + 1;

    vci_inserter i_vci_inserter (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .LINE_START(ls), .LINE_NUM(num), .NTSC_MODE(ntsc), .PIX_IN(pix),
        .PIX_OUT(pix_out), .VBI_ACTIVE(vbi));
    vci_rx_model i_vci_rx_model (.CLK(clk), .LINE_START(ls), .PIX_OUT(pix_out),
        .cc_bits(cc_bits), .cg_bits(cg_bits), .runin_peaks(peaks));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic summarize;
        $display("checked %0d, errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Classic cycle: request held until ack is sampled, one idle cycle after
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic line(input logic [9:0] n, input logic m, input int w);
        num <= n;
        ntsc <= m;
        ls <= 1'b1;
        @(posedge clk);
        ls <= 1'b0;
        repeat (w) @(posedge clk);
    endtask

    function automatic logic [5:0] crc6(input logic [13:0] d);
        logic [5:0] c;
        logic fb;
        c = CRC_PRESET;
        for (int i = 0; i < 14; i++) begin
            fb = d[i] ^ c[5];
            c = {c[4:0], 1'b0} ^ {4'h0, fb, fb};
        end
        return c;
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        for (int a = 0; a <= 36; a += 4) begin
            wb(1'b0, 8'(a), 8'h00);
            check(rd, 32'h0);
        end
        wb(1'b1, 8'h24, 8'hff);
        wb(1'b0, 8'h24, 8'h00);
        check(rd, 32'h0);
        wb(1'b1, ADR_CC1, 8'h5a);
        wb(1'b0, ADR_CC1, 8'h00);
        check(rd, 32'h5a);
        $display("test registers done");
    endtask

    // The other caption pair gets inverted bytes, so a wrong pick shows
    task automatic t_cap(input logic [9:0] n, input logic [7:0] a0, input logic [7:0] b0,
        input logic [7:0] b1);
        int base;
        wb(1'b1, ADR_CTRL, 8'h18);
        wb(1'b1, a0, b0);
        wb(1'b1, a0 + 8'h04, b1);
        wb(1'b1, a0 ^ 8'h08, ~b0);
        wb(1'b1, a0 ^ 8'h0c, ~b1);
        pix <= 8'hff;
        base = leaks;
        line(n, 1'b1, 15700);
        check(cc_bits, {~^b1[6:0], b1[6:0], ~^b0[6:0], b0[6:0], 3'b100});
        check(peaks, RUNIN_CYCLES);
        check(leaks - base, 0);
        check(vbi, 1'b1);
        pix <= 8'h55;
        $display("test caption line %0d done", n);
    endtask

    task automatic t_cg(input logic [9:0] n, input logic [7:0] ctl);
        logic [19:0] p;
        p = {4'h9, 8'h3c, 8'ha5};
        if (ctl[0]) p[19:14] = {<<{crc6(p[13:0])}};
        wb(1'b1, ADR_COPY0, 8'hf9);
        wb(1'b1, ADR_COPY1, 8'h3c);
        wb(1'b1, ADR_COPY2, 8'ha5);
        wb(1'b1, ADR_CTRL, ctl);
        line(n, 1'b1, 14700);
        check(cg_bits, {p, 1'b1});
        $display("test copy line %0d done", n);
    endtask

    // Looks inside the reference pulse: the pixel stream must pass untouched
    task automatic t_gate(input logic [9:0] n, input logic m, input logic [7:0] ctl);
        wb(1'b1, ADR_CTRL, ctl);
        line(n, m, int'(CG_START_CYC) + int'(CG_BIT_CYC) / 2);
        check(pix_out, 8'h55);
        check(vbi, 1'b0);
        $display("test copy gate line %0d done", n);
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs;
        t_cap(10'd21, ADR_CC0, 8'h14, 8'h6b);
        t_cap(10'd284, ADR_CCX0, 8'hc5, 8'h2e);
        t_cg(10'd20, 8'h03);
        t_cg(10'd283, 8'h04);
        t_gate(10'd283, 1'b1, 8'h02);
        t_gate(10'd20, 1'b0, 8'h06);
        t_cap(10'd21, ADR_CC0, 8'h00, 8'h00);
        summarize;
    end

    // Tests need about 83000 cycles
    initial begin
        repeat (92000) @(posedge clk);
        errors++;
        summarize;
    end
endmodule // tb_vbi_caption_copy_generation_info_inserter
